/* File: ecph_periph_model.sv */
// behavioural peripheral on the far side of the parallel link
`timescale 1ns/1ps
`default_nettype none
module ecph_periph_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_bus,
	input  wire logic       i_stb,
	input  wire logic       i_hack,
	input  wire logic       i_init,
	output var logic  [7:0] o_pd,
	output var logic        o_cack,
	output var logic        o_busy,
	output var logic        o_perr,
	output var logic        o_sel,
	output var logic        o_fault
);
	int         stall  = 0;
	int         sent   = 0;
	logic       rev_en = 1'b0;
	logic [8:0] rx_q[$];
	logic [8:0] tx_q[$];
	logic [8:0] w;
	// idle levels at start
	initial begin
		o_pd = 8'h5a;
		o_cack = 1'b1;
		o_busy = 1'b0;
		o_perr = 1'b1;
		o_sel = 1'b1;
		o_fault = 1'b1;
	end
	// forward: latch at strobe, busy high until stall cycles after strobe released
	initial forever begin
		@(negedge i_clock);
		if (!i_stb) begin
			rx_q.push_back({i_hack, i_bus});
			repeat (stall) @(negedge i_clock);
			o_busy <= 1'b1;
			while (!i_stb) @(negedge i_clock);
			repeat (stall) @(negedge i_clock);
			o_busy <= 1'b0;
		end
	end
	// direction: ack level follows the reverse request, late
	initial forever begin
		@(negedge i_clock);
		if (rev_en && i_init != o_perr) begin
			repeat (stall) @(negedge i_clock);
			o_perr <= i_init;
		end
	end
	// reverse: drive byte only while host ack is low, then release
	initial forever begin
		@(negedge i_clock);
		if (!o_perr && !i_init && !i_hack && tx_q.size() != 0) begin
			w = tx_q.pop_front();
			o_pd <= w[7:0];
			o_busy <= w[8];
			@(negedge i_clock);
			o_cack <= 1'b0;
			while (!i_hack) @(negedge i_clock);
			o_cack <= 1'b1;
			o_pd <= ~w[7:0];
			o_busy <= 1'b0;
			sent++;
			repeat (stall) @(negedge i_clock);
		end
	end
endmodule : ecph_periph_model
`default_nettype wire

/* File: ecph_pkg.sv */
// shared constants and types for the host-side extended parallel port
package ecph_pkg;

	// host word and register address
	localparam int unsigned WORD_W       = 8;
	localparam int unsigned ADDR_W       = 11;

	// register offsets from the port base
	localparam logic [10:0] OFS_DATA     = 11'h000;
	localparam logic [10:0] OFS_STATUS   = 11'h001;
	localparam logic [10:0] OFS_CONTROL  = 11'h002;
	localparam logic [10:0] OFS_QUEUE    = 11'h400;
	localparam logic [10:0] OFS_CFGB     = 11'h401;
	localparam logic [10:0] OFS_XCTL     = 11'h402;

	// values of the mode field
	localparam logic [2:0]  MODE_SPP     = 3'h0;
	localparam logic [2:0]  MODE_BIDIR   = 3'h1;
	localparam logic [2:0]  MODE_FIFO    = 3'h2;
	localparam logic [2:0]  MODE_EXT     = 3'h3;
	localparam logic [2:0]  MODE_EPP     = 3'h4;
	localparam logic [2:0]  MODE_TEST    = 3'h6;
	localparam logic [2:0]  MODE_CFG     = 3'h7;

	// line_control field positions
	localparam int unsigned LCTL_STROBE  = 0;
	localparam int unsigned LCTL_AUTOFD  = 1;
	localparam int unsigned LCTL_INIT    = 2;
	localparam int unsigned LCTL_SELIN   = 3;
	localparam int unsigned LCTL_ACKIE   = 4;
	localparam int unsigned LCTL_DIR     = 5;

	// extended_control field positions
	localparam int unsigned XCTL_MODE    = 5;
	localparam int unsigned XCTL_ERRIE_B = 4;
	localparam int unsigned XCTL_DMA_REQUEST_ENABLE   = 3;
	localparam int unsigned XCTL_SVC     = 2;
	localparam int unsigned XCTL_FULL    = 1;
	localparam int unsigned XCTL_EMPTY   = 0;

	// reset values and fixed read values
	localparam logic [7:0]  DATA_RESET   = 8'h00;
	localparam logic [5:0]  LCTL_RESET   = 6'h00;
	localparam logic [7:0]  XCTL_RESET   = 8'h00;
	localparam logic [7:0]  CFGA_VALUE   = 8'h10;
	localparam logic        CFGB_COMPRESS = 1'b0;

	// shared queue geometry and service threshold
	localparam int unsigned FIFO_DEPTH   = 16;
	localparam logic [4:0]  FIFO_FULL_CNT = 5'h10;
	localparam logic [4:0]  SVC_THRESH   = 5'h08;

	// data setup time before the strobe falls
	localparam int unsigned CLOCK_NS     = 100;
	localparam int unsigned SETUP_NS     = 100;
	localparam int unsigned SETUP_CYC    = (SETUP_NS + CLOCK_NS - 1) / CLOCK_NS;

	typedef enum logic [1:0] {
		FW_IDLE   = 2'b00,
		FW_SETUP  = 2'b01,
		FW_STROBE = 2'b11,
		FW_WAIT   = 2'b10
	} ecph_fw_t;

	typedef enum logic [1:0] {
		DIR_FWD    = 2'b00,
		DIR_TO_REV = 2'b01,
		DIR_REV    = 2'b11,
		DIR_TO_FWD = 2'b10
	} ecph_dir_t;

	typedef enum logic [1:0] {
		RV_IDLE  = 2'b00,
		RV_REQ   = 2'b01,
		RV_LATCH = 2'b11,
		RV_PUSH  = 2'b10
	} ecph_rv_t;

endpackage : ecph_pkg

/* File: ecph_port.sv */
// host-side extended capabilities parallel port: registers, queue, link engines
// Summary of operation
// - epp mode: control may override only write line; control still drives strobe, auto feed, init and select in
// - host bus word is eight bits
// - status and control reachable in every mode
// - all queue ports share one 16-byte queue
// - config b reports selected irq and dma
// - no negotiation; dma burst both directions
// - compatibility mode handshake runs in hardware
// - run byte consumed, next byte repeated
// - compression optional; not built, flag reads zero
// - forward strobe interlocked with peripheral busy
// - host ack low requests reverse byte
// - no data drive until reverse ack permits
// - fault input in forward raises error interrupt
// - reverse request low selects reverse direction
// - mode select held deasserted in ext mode
// - three-bit mode field selects port mode
// - status bit 7 inverted busy, 3-6 direct
`timescale 1ns/1ps
`default_nettype none
module ecph_port
	import ecph_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_cs,
	input  wire logic [10:0] i_addr,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_dack,
	output logic             o_drq,
	input  wire logic [2:0]  i_irq_sel,
	input  wire logic [2:0]  i_dma_sel,
	input  wire logic [7:0]  i_periph_data_bus,
	output logic      [7:0]  o_periph_data_bus,
	output logic             o_periph_data_bus_oe,
	output logic             o_host_clock_strobe,
	output logic             o_host_ack_output,
	output logic             o_initialize_output,
	output logic             o_mode_select_output,
	output logic             o_epp_write_b,
	input  wire logic        i_periph_clock_ack,
	input  wire logic        i_periph_ack_busy,
	input  wire logic        i_paper_error_input,
	input  wire logic        i_select,
	input  wire logic        i_fault_input,
	output logic             o_error_irq
);

	typedef struct packed {
		logic [7:0] data;
		logic [5:0] lctl;
		logic [2:0] mode;
		logic       err_en_b;
		logic       dma_en;
		logic       svc;
		ecph_fw_t   fw;
		logic [1:0] setup;
		logic [8:0] fw_word;
		ecph_dir_t  dir;
		ecph_rv_t   rv;
		logic [7:0] rv_byte;
		logic       rv_cmd;
		logic [7:0] run;
		logic [7:0] reps;
		logic [7:0] rdata;
		logic       err_irq;
	} ecph_port_st_t;

	localparam ecph_port_st_t ST_RESET = '{
		data:     DATA_RESET,
		lctl:     LCTL_RESET,
		mode:     XCTL_RESET[7:5],
		err_en_b: XCTL_RESET[XCTL_ERRIE_B],
		dma_en:   XCTL_RESET[XCTL_DMA_REQUEST_ENABLE],
		svc:      XCTL_RESET[XCTL_SVC],
		fw:       FW_IDLE,
		dir:      DIR_FWD,
		rv:       RV_IDLE,
		default:  '0
	};

	ecph_port_st_t s, n;

	// address match on the selected port window
	function automatic logic hit(input logic [10:0] a, input logic [10:0] ofs);
		return i_cs && (a == ofs);
	endfunction : hit

	logic       mode_ext;
	logic       mode_queue;
	logic       fwd_run;
	logic       rev_want;
	logic       q_sel;
	logic       host_wr_q;
	logic       host_wr_a;
	logic       host_rd_q;
	logic       q_push;
	logic [8:0] q_wdata;
	logic       q_pop;
	logic [8:0] q_head;
	logic       q_full;
	logic       q_empty;
	logic [4:0] q_count;
	logic       q_flush;
	logic       rv_push;
	logic       sk_in_valid;
	logic       sk_in_ready;
	logic       sk_valid;
	logic       sk_ready;
	logic [8:0] sk_data;
	logic [7:0] rd_mux;

	// mode decode for the queue modes and the link direction
	assign mode_ext    = (s.mode == MODE_EXT);
	assign mode_queue  = (s.mode == MODE_FIFO) || mode_ext;
	assign fwd_run     = (s.mode == MODE_FIFO) || (mode_ext && s.dir == DIR_FWD);
	assign rev_want    = mode_ext && s.lctl[LCTL_DIR];

	// host and dma accesses to the one shared queue
	assign q_sel       = (hit(i_addr, OFS_QUEUE) && (mode_queue || s.mode == MODE_TEST))
		|| i_dack;
	assign host_wr_q   = i_wr && q_sel;
	assign host_wr_a   = i_wr && hit(i_addr, OFS_DATA) && mode_ext;
	assign host_rd_q   = i_rd && q_sel;
	assign q_push      = rv_push || host_wr_q || host_wr_a;
	assign q_wdata     = rv_push ? {1'b0, s.rv_byte} : {host_wr_a, i_wdata};
	assign sk_in_valid = fwd_run && !q_empty;
	assign q_pop       = (sk_in_valid && sk_in_ready) || (host_rd_q && !sk_in_valid);
	assign q_flush     = i_wr && hit(i_addr, OFS_XCTL)
		&& (i_wdata[7:5] == MODE_SPP || i_wdata[7:5] == MODE_BIDIR);

	ecph_queue u_queue (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.i_flush     (q_flush),
		.i_push      (q_push),
		.i_push_data (q_wdata),
		.i_pop       (q_pop),
		.o_head      (q_head),
		.o_full      (q_full),
		.o_empty     (q_empty),
		.o_count     (q_count)
	);

	ecph_skid u_skid (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_flush (q_flush),
		.i_valid (sk_in_valid),
		.o_ready (sk_in_ready),
		.i_data  (q_head),
		.o_valid (sk_valid),
		.i_ready (sk_ready),
		.o_data  (sk_data)
	);

	// the strobe engine takes a word only while the peripheral is not busy
	assign sk_ready = (s.fw == FW_IDLE) && !i_periph_ack_busy;
	assign rv_push  = (s.rv == RV_PUSH) && !q_full;

	// register read selection, registered into the read data
	always_comb begin
		rd_mux = 8'h00;
		if (hit(i_addr, OFS_STATUS)) begin
			rd_mux = {~i_periph_ack_busy, i_periph_clock_ack, i_paper_error_input,
				i_select, i_fault_input, 3'h0};
		end else if (hit(i_addr, OFS_CONTROL)) begin
			rd_mux = {2'h0, s.lctl};
		end else if (hit(i_addr, OFS_XCTL)) begin
			rd_mux = {s.mode, s.err_en_b, s.dma_en, s.svc, q_full, q_empty};
		end else if (hit(i_addr, OFS_DATA) && s.mode == MODE_BIDIR && s.lctl[LCTL_DIR]) begin
			rd_mux = i_periph_data_bus;
		end else if (hit(i_addr, OFS_DATA) && s.mode == MODE_SPP) begin
			rd_mux = s.data;
		end else if (hit(i_addr, OFS_QUEUE) && s.mode == MODE_CFG) begin
			rd_mux = CFGA_VALUE;
		end else if (hit(i_addr, OFS_CFGB) && s.mode == MODE_CFG) begin
			rd_mux = {CFGB_COMPRESS, s.err_irq, i_irq_sel, i_dma_sel};
		end else if (q_sel) begin
			rd_mux = q_head[7:0];
		end
	end

	// next state: registers, forward, direction and reverse engines
	always_comb begin
		n = s;
		if (i_rd) begin
			n.rdata = rd_mux;
		end
		if (i_wr && hit(i_addr, OFS_DATA) && !mode_ext) begin
			n.data = i_wdata;
		end
		if (i_wr && hit(i_addr, OFS_CONTROL)) begin
			n.lctl = i_wdata[5:0];
		end
		if (i_wr && hit(i_addr, OFS_XCTL)) begin
			n.mode     = i_wdata[7:5];
			n.err_en_b = i_wdata[XCTL_ERRIE_B];
			n.dma_en   = i_wdata[XCTL_DMA_REQUEST_ENABLE];
			n.svc      = i_wdata[XCTL_SVC];
		end
		// threshold sets the service flag after any software clear, only with dma off in a queue mode
		if (!s.dma_en && mode_queue && (fwd_run ? (q_count <= SVC_THRESH)
			: (q_count >= FIFO_FULL_CNT - SVC_THRESH))) begin
			n.svc = 1'b1;
		end
		n.err_irq = (s.dir == DIR_FWD) && !i_fault_input && !s.err_en_b;

		// forward: setup, strobe low until busy, release until not busy
		unique case (s.fw)
			FW_IDLE: begin
				if (sk_valid && sk_ready) begin
					n.fw_word = sk_data;
					n.setup   = 2'(SETUP_CYC - 1);
					n.fw      = FW_SETUP;
				end
			end
			FW_SETUP: begin
				if (s.setup == 2'h0) begin
					n.fw = FW_STROBE;
				end else begin
					n.setup = s.setup - 2'h1;
				end
			end
			FW_STROBE: begin
				if (i_periph_ack_busy) begin
					n.fw = FW_WAIT;
				end
			end
			FW_WAIT: begin
				if (!i_periph_ack_busy) begin
					n.fw = FW_IDLE;
				end
			end
		endcase

		// direction change waits on the peripheral's reverse ack
		unique case (s.dir)
			DIR_FWD: begin
				if (rev_want && s.fw == FW_IDLE && !sk_valid) begin
					n.dir = DIR_TO_REV;
				end
			end
			DIR_TO_REV: begin
				if (!i_paper_error_input) begin
					n.dir = DIR_REV;
				end
			end
			DIR_REV: begin
				if (!rev_want && s.rv == RV_IDLE) begin
					n.dir = DIR_TO_FWD;
				end
			end
			DIR_TO_FWD: begin
				if (i_paper_error_input) begin
					n.dir = DIR_FWD;
				end
			end
		endcase

		// reverse: request, latch on clock ack, expand runs into the queue
		unique case (s.rv)
			RV_IDLE: begin
				if (s.dir == DIR_REV && rev_want && !q_full) begin
					n.rv = RV_REQ;
				end
			end
			RV_REQ: begin
				if (!i_periph_clock_ack) begin
					n.rv_byte = i_periph_data_bus;
					n.rv_cmd  = !i_periph_ack_busy;
					n.rv      = RV_LATCH;
				end else if (!rev_want) begin
					n.rv = RV_IDLE; // withdraw the request so the turn to forward can finish
				end
			end
			RV_LATCH: begin
				if (i_periph_clock_ack) begin
					if (s.rv_cmd) begin
						if (!s.rv_byte[7]) begin
							n.run = {1'b0, s.rv_byte[6:0]};
						end
						n.rv = RV_IDLE;
					end else begin
						n.reps = s.run + 8'h01;
						n.run  = 8'h00;
						n.rv   = RV_PUSH;
					end
				end
			end
			RV_PUSH: begin
				if (rv_push) begin
					n.reps = s.reps - 8'h01;
					if (s.reps == 8'h01) begin
						n.rv = RV_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= ST_RESET;
		end else begin
			s <= n;
		end
	end

	// pin drive per mode; queue modes hand the lines to the engines
	always_comb begin
		o_periph_data_bus              = mode_queue ? s.fw_word[7:0] : s.data;
		o_host_clock_strobe  = mode_queue ? (s.fw != FW_STROBE) : ~s.lctl[LCTL_STROBE];
		o_host_ack_output    = ~s.lctl[LCTL_AUTOFD];
		o_initialize_output  = s.lctl[LCTL_INIT];
		o_mode_select_output = ~s.lctl[LCTL_SELIN];
		o_epp_write_b        = 1'b1;
		o_periph_data_bus_oe           = !s.lctl[LCTL_DIR];
		if (s.mode == MODE_SPP || s.mode == MODE_FIFO) begin
			o_periph_data_bus_oe = 1'b1;
		end
		if (s.mode == MODE_EPP) begin
			o_epp_write_b = s.lctl[LCTL_DIR];
		end
		if (mode_ext) begin
			o_mode_select_output = 1'b1;
			o_initialize_output  = !(s.dir == DIR_TO_REV || s.dir == DIR_REV);
			o_periph_data_bus_oe           = (s.dir == DIR_FWD);
			if (s.dir == DIR_FWD) begin
				o_host_ack_output = (s.fw == FW_IDLE) || !s.fw_word[8];
			end else begin
				o_host_ack_output = (s.rv != RV_REQ);
			end
		end
	end

	// dma request follows queue room or content in the active direction
	assign o_drq = s.dma_en && ((fwd_run && mode_queue && !q_full)
		|| (s.dir == DIR_REV && !q_empty));
	assign o_rdata     = s.rdata;
	assign o_error_irq = s.err_irq;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	epp_write_a: assert property ((s.mode == MODE_EPP) |-> o_epp_write_b == s.lctl[LCTL_DIR])
		else $error("epp write line does not follow direction bit");
	status_bits_a: assert property (i_rd && hit(i_addr, OFS_STATUS) |=>
		o_rdata == {~$past(i_periph_ack_busy), $past(i_periph_clock_ack),
		$past(i_paper_error_input), $past(i_select), $past(i_fault_input), 3'h0})
		else $error("status read does not match input levels");
	cfga_read_a: assert property (i_rd && hit(i_addr, OFS_QUEUE) && s.mode == MODE_CFG
		|=> o_rdata == 8'h10)
		else $error("config a read value wrong");
	cfgb_reflect_a: assert property (i_rd && hit(i_addr, OFS_CFGB) && s.mode == MODE_CFG
		|=> o_rdata[5:0] == {$past(i_irq_sel), $past(i_dma_sel)})
		else $error("config b does not report irq and dma selection");
	mode_select_a: assert property (mode_ext |-> o_mode_select_output)
		else $error("mode select asserted in ext mode");
	no_drive_a: assert property (mode_ext && s.dir != DIR_FWD |-> !o_periph_data_bus_oe)
		else $error("data bus driven before reverse ack allows");
	strobe_hold_a: assert property (s.fw == FW_STROBE && !i_periph_ack_busy && mode_queue
		|=> !o_host_clock_strobe)
		else $error("strobe released before busy seen");
	rev_dir_a: assert property (mode_ext && s.dir == DIR_REV |-> !o_initialize_output)
		else $error("reverse request not low in reverse");
	err_irq_a: assert property (s.dir == DIR_FWD && !i_fault_input && !s.err_en_b
		|=> o_error_irq)
		else $error("fault did not raise error interrupt");
	cmd_flag_a: assert property (mode_ext && s.dir == DIR_FWD && s.fw == FW_STROBE
		&& s.fw_word[8] |-> !o_host_ack_output)
		else $error("command byte sent with data flag");
	run_expand_a: assert property (s.rv == RV_LATCH && i_periph_clock_ack && !s.rv_cmd
		|=> s.rv == RV_PUSH && s.reps == $past(s.run) + 8'h01)
		else $error("run count not applied to following byte");

endmodule : ecph_port
`default_nettype wire

/* File: ecph_queue.sv */
// shared sixteen-byte queue with tag bit, last-byte reread on empty
`timescale 1ns/1ps
`default_nettype none
module ecph_queue
	import ecph_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_rst_b,
	input  wire logic       i_flush,
	input  wire logic       i_push,
	input  wire logic [8:0] i_push_data,
	input  wire logic       i_pop,
	output logic      [8:0] o_head,
	output logic            o_full,
	output logic            o_empty,
	output logic      [4:0] o_count
);

	typedef struct packed {
		logic [15:0][8:0] mem;
		logic [3:0]       wr;
		logic [3:0]       rd;
		logic [4:0]       cnt;
		logic [8:0]       last;
	} ecph_queue_st_t;

	ecph_queue_st_t s, n;
	logic           do_push;
	logic           do_pop;

	// status and head word come straight from the state
	assign o_full  = (s.cnt == FIFO_FULL_CNT);
	assign o_empty = (s.cnt == 5'h00);
	assign o_count = s.cnt;
	assign o_head  = o_empty ? s.last : s.mem[s.rd];
	assign do_push = i_push && !o_full;
	assign do_pop  = i_pop && !o_empty;

	// full queue drops writes, empty queue keeps the last word
	always_comb begin
		n = s;
		if (do_push) begin
			n.mem[s.wr] = i_push_data;
			n.wr        = s.wr + 4'h1;
		end
		if (do_pop) begin
			n.last = s.mem[s.rd];
			n.rd   = s.rd + 4'h1;
		end
		n.cnt = s.cnt + {4'h0, do_push} - {4'h0, do_pop};
		if (i_flush) begin
			n.wr  = 4'h0;
			n.rd  = 4'h0;
			n.cnt = 5'h00;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule : ecph_queue
`default_nettype wire

/* File: ecph_skid.sv */
// two-entry buffer between the queue and the forward strobe engine
`timescale 1ns/1ps
`default_nettype none
module ecph_skid
	import ecph_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_rst_b,
	input  wire logic       i_flush,
	input  wire logic       i_valid,
	output logic            o_ready,
	input  wire logic [8:0] i_data,
	output logic            o_valid,
	input  wire logic       i_ready,
	output logic      [8:0] o_data
);

	typedef struct packed {
		logic [1:0][8:0] word;
		logic [1:0]      cnt;
	} ecph_skid_st_t;

	ecph_skid_st_t s, n;
	logic          take;
	logic          give;

	assign o_ready = (s.cnt != 2'h2);
	assign o_valid = (s.cnt != 2'h0);
	assign o_data  = s.word[0];
	assign take    = i_valid && o_ready;
	assign give    = o_valid && i_ready;

	// shift out the head, then append at the first free slot
	always_comb begin
		n = s;
		if (give) begin
			n.word[0] = s.word[1];
			n.cnt     = n.cnt - 2'h1;
		end
		if (take) begin
			n.word[n.cnt[0]] = i_data;
			n.cnt            = n.cnt + 2'h1;
		end
		if (i_flush) begin
			n.cnt = 2'h0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule : ecph_skid
`default_nettype wire

/* File: test_ecp_parallel_port_host_side.sv */
// self-checking bench for the host-side extended parallel port
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s expected %h seen %h", n, e, g); end end
`define wt(c) begin for (k = 0; k < 3000 && !(c); k++) @(negedge clk); \
	if (!(c)) begin n_fail++; $display("[ERR] wait ran out"); print_verdict(); end end
module test_ecp_parallel_port_host_side
	import ecph_pkg::*;
;
	logic        clk     = 1'b0;
	logic        rst_b   = 1'b0;
	logic        cs      = 1'b0;
	logic        rd      = 1'b0;
	logic        wr      = 1'b0;
	logic        dack    = 1'b0;
	logic [10:0] addr    = 11'h000;
	logic [7:0]  wdata   = 8'h00;
	logic [2:0]  irq_sel = 3'h0;
	logic [2:0]  dma_sel = 3'h0;
	logic [31:0] seed    = 32'h00d77e57;
	logic        use_dma = 1'b0;
	logic        ext_on  = 1'b0;
	logic [7:0]  rdata, pd_out, pd, bus, b, v;
	logic        oe, stb, hack, init, msel, eppw, drq, irq;
	logic        cack, busy, perr, sel, fault;
	logic [8:0]  w;
	logic [8:0]  exp_q[$];
	int          n_fail  = 0;
	int          samples_checked = 0;
	int          k, n;

	// clock and shared data wire
	initial forever #50 clk = ~clk;
	assign bus = oe ? pd_out : pd;

	ecph_port dut (
		.i_clock(clk), .i_rst_b(rst_b), .i_cs(cs), .i_addr(addr), .i_rd(rd),
		.i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .i_dack(dack), .o_drq(drq),
		.i_irq_sel(irq_sel), .i_dma_sel(dma_sel), .i_periph_data_bus(bus), .o_periph_data_bus(pd_out),
		.o_periph_data_bus_oe(oe), .o_host_clock_strobe(stb), .o_host_ack_output(hack),
		.o_initialize_output(init), .o_mode_select_output(msel), .o_epp_write_b(eppw),
		.i_periph_clock_ack(cack), .i_periph_ack_busy(busy), .i_paper_error_input(perr),
		.i_select(sel), .i_fault_input(fault), .o_error_irq(irq)
	);

	ecph_periph_model periph (
		.i_clock(clk), .i_bus(bus), .i_stb(stb), .i_hack(hack), .i_init(init),
		.o_pd(pd), .o_cack(cack), .o_busy(busy), .o_perr(perr), .o_sel(sel),
		.o_fault(fault)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// one-cycle write strobe, by chip select or by dma acknowledge
	task automatic put(input logic [10:0] a, input logic [7:0] d);
		@(negedge clk);
		cs <= !use_dma;
		dack <= use_dma;
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(negedge clk);
		cs <= 1'b0;
		dack <= 1'b0;
		wr <= 1'b0;
	endtask : put

	// one-cycle read strobe, data taken once registered
	task automatic get(input logic [10:0] a, output logic [7:0] d);
		@(negedge clk);
		cs <= 1'b1;
		addr <= a;
		rd <= 1'b1;
		@(negedge clk);
		cs <= 1'b0;
		rd <= 1'b0;
		d = rdata;
	endtask : get

	task automatic rchk(input logic [10:0] a, input logic [7:0] e, input string nm);
		get(a, v);
		`chk(nm, e, v)
	endtask : rchk

	// peripheral line levels: busy, clock ack, reverse ack, select, fault
	task automatic levels(input logic [4:0] l);
		periph.o_busy = l[4];
		periph.o_cack = l[3];
		periph.o_perr = l[2];
		periph.o_sel = l[1];
		periph.o_fault = l[0];
	endtask : levels

	// compare bytes seen by the peripheral with the model queue
	task automatic drain(input int cnt, input logic [8:0] mask);
		logic [8:0] got;
		`wt(periph.rx_q.size() >= cnt)
		for (int i = 0; i < cnt; i++) begin
			w = exp_q.pop_front();
			got = periph.rx_q.pop_front();
			`chk("fwd_byte", w & mask, got & mask)
		end
		// let the last handshake finish before the mode or direction moves
		`wt(stb === 1'b1 && busy === 1'b0)
	endtask : drain

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// link watch in ext mode
	always @(negedge clk) begin
		if (ext_on) begin
			`chk("mode_select", 1'b1, msel)
			if (!init && !hack) `chk("rev_ack", 1'b0, perr)
		end
	end

	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		$display("[ERR] run ran out of time");
		print_verdict();
	end

	initial begin
		irq_sel = 3'(rnd());
		dma_sel = 3'(rnd());
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		rchk(OFS_CONTROL, 8'h00, "control");
		// every defined mode, random line levels
		for (int m = 0; m < 8; m++) begin
			if (m == 5) continue;
			put(OFS_XCTL, {3'(m), 5'h10});
			get(OFS_XCTL, v);
			`chk("mode", 3'(m), v[7:5])
			`chk("epp_write", (m != 4), eppw)
			b = 8'(rnd());
			levels(b[7:3]);
			rchk(OFS_STATUS, {~b[7], b[6:3], 3'h0}, "status");
			if (m == 7) begin
				rchk(OFS_QUEUE, 8'h10, "config_a");
				rchk(OFS_CFGB, {2'b00, irq_sel, dma_sel}, "config_b");
			end
		end
		// fault low raises the error interrupt unless masked
		put(OFS_XCTL, {MODE_SPP, 5'h00});
		levels(5'b01110);
		repeat (3) @(negedge clk);
		`chk("error_irq", 1'b1, irq)
		put(OFS_XCTL, {MODE_SPP, 5'h10});
		repeat (3) @(negedge clk);
		`chk("error_irq", 1'b0, irq)
		levels(5'b01111);
		// test queue: fill past full, drain past empty
		put(OFS_XCTL, {MODE_TEST, 5'h10});
		for (int i = 0; i < 17; i++) begin
			w = {1'b0, 8'(rnd())};
			put(OFS_QUEUE, w[7:0]);
			if (i < 16) exp_q.push_back(w);
		end
		get(OFS_XCTL, v);
		`chk("full_empty", 2'b10, v[1:0])
		for (int i = 0; i < 17; i++) begin
			if (i < 16) w = exp_q.pop_front();
			get(OFS_QUEUE, v);
			`chk("test_queue", w[7:0], v)
		end
		get(OFS_XCTL, v);
		`chk("full_empty", 2'b01, v[1:0])
		// compatibility queue fed by dma, peripheral stalling
		put(OFS_XCTL, {MODE_SPP, 5'h10});
		put(OFS_XCTL, {MODE_FIFO, 5'h18});
		periph.stall = 2;
		`chk("dma_request", 1'b1, drq)
		use_dma = 1'b1;
		for (int i = 0; i < 6; i++) begin
			w = {1'b1, 8'(rnd())};
			put(OFS_QUEUE, w[7:0]);
			exp_q.push_back(w);
		end
		use_dma = 1'b0;
		drain(6, 9'h0ff);
		// ext forward: address and data bytes with their marker
		put(OFS_XCTL, {MODE_SPP, 5'h10});
		put(OFS_XCTL, {MODE_EXT, 5'h10});
		ext_on = 1'b1;
		periph.stall = 1;
		for (int i = 0; i < 8; i++) begin
			w = {1'(i % 3 != 0), 8'(rnd())};
			put(w[8] ? OFS_QUEUE : OFS_DATA, w[7:0]);
			exp_q.push_back(w);
		end
		drain(8, 9'h1ff);
		// reverse: run-length expansion, channel address dropped
		periph.o_fault = 1'b0;
		rchk(OFS_STATUS, 8'hf0, "request_hint");
		periph.rev_en = 1'b1;
		periph.stall = 3;
		put(OFS_CONTROL, 8'h20);
		`wt(init === 1'b0)
		periph.o_fault = 1'b1;
		`chk("oe_reverse", 1'b0, oe)
		for (int i = 0; i < 4; i++) begin
			b = 8'(rnd());
			n = (i == 1) ? 1 : b[1:0] + 1;
			periph.tx_q.push_back({1'b0, (i == 1), 5'h00, b[1:0]});
			periph.tx_q.push_back({1'b1, b});
			repeat (n) exp_q.push_back({1'b0, b});
		end
		`wt(periph.sent == 8)
		repeat (8) @(negedge clk);
		while (exp_q.size() != 0) begin
			w = exp_q.pop_front();
			rchk(OFS_QUEUE, w[7:0], "reverse_byte");
		end
		put(OFS_CONTROL, 8'h00);
		`wt(init === 1'b1)
		`chk("oe_hold", 1'b0, oe)
		`wt(oe === 1'b1)
		`chk("reverse_ack", 1'b1, perr)
		print_verdict();
	end
endmodule : test_ecp_parallel_port_host_side
`default_nettype wire
